// ==== hw/psdi_pkg.sv ====
`default_nettype none

package psdi_pkg;

  // ----------------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSDI_MODE_SINGLE = 2'b00,
    PSDI_MODE_DOUBLE = 2'b01,
    PSDI_MODE_AUTO   = 2'b10,
    PSDI_MODE_MANUAL = 2'b11
  } psdi_mode_t;

  // ----------------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PSDI_ST_LOCKED  = 3'b000,
    PSDI_ST_WAIT    = 3'b001,
    PSDI_ST_BREAK   = 3'b010,
    PSDI_ST_CYCLE   = 3'b011,
    PSDI_ST_GUARD   = 3'b100,
    PSDI_ST_FAULT   = 3'b101
  } psdi_state_t;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned TICK_HZ         = 1000;
  localparam int unsigned TICK_DIV        = CLK_HZ / TICK_HZ;
  localparam int unsigned IDLE_WAIT_MS    = 30000;
  localparam int unsigned BREAK_MIN_MS    = 300;
  localparam int unsigned FEEDBACK_MIN_MS = 100;
  localparam int unsigned MS_W            = 16;
  localparam int unsigned BREAKS_SINGLE   = 1;
  localparam int unsigned BREAKS_DOUBLE   = 2;

  // Status and relay outputs travel together.
  typedef struct packed {
    logic relay_a;
    logic relay_b;
    logic safety_output_state;
    logic fault;
    logic reset_needed;
  } psdi_out_t;

endpackage : psdi_pkg

`default_nettype wire

// ==== hw/psdi_channel.sv ====
`timescale 1ns/100ps
`default_nettype none

// One supervision channel: synchronises its curtain input and measures
// how long the curtain has been interrupted, in millisecond ticks.
module psdi_channel
#(
  parameter int unsigned MS_W = 16
)
(
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            tick_ms,
  input  wire logic            curtain_clear_pin,
  output var  logic            clear,
  output var  logic [MS_W-1:0] broken_ms
);

  logic sync1_reg;
  logic sync2_reg;
  logic [MS_W-1:0] cnt_reg;
  wire  [MS_W-1:0] cnt_next;
  wire             sat;

  assign sat      = &cnt_reg;
  assign cnt_next = sync2_reg ? '0 :
                    (tick_ms && !sat) ? cnt_reg + 1'b1 : cnt_reg;
  assign clear     = sync2_reg;
  assign broken_ms = cnt_reg;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      cnt_reg   <= '0;
    end
    else
    begin
      sync1_reg <= curtain_clear_pin;
      sync2_reg <= sync1_reg;
      cnt_reg   <= cnt_next;
    end
  end

endmodule : psdi_channel

`default_nettype wire

// ==== hw/psdi_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Two setting inputs select single, double, auto guard or manual guard.
// - Two independent channels supervise the curtain continuously.
// - Single break mode starts a cycle after one interruption.
// - Break modes take the feedback pulse as cycle completion.
// - After a completed cycle wait up to 30 s for the next break.
// - Single mode: wait expiry requires a new reset.
// - Breaks count only when longer than 300 ms.
// - Double break mode starts a cycle after two breaks in a window.
// - Double mode: wait expiry requires a new reset.
// - Auto guard follows curtain clear with no reinitiation.
// - Manual guard needs reset after clear, no reinitiation.
// - Auxiliary status output reports the safety output state.
module psdi_ctrl
#(
  parameter int unsigned TICK_DIV     = psdi_pkg::TICK_DIV,
  parameter int unsigned IDLE_WAIT_MS = psdi_pkg::IDLE_WAIT_MS,
  parameter int unsigned BREAK_MIN_MS = psdi_pkg::BREAK_MIN_MS,
  parameter int unsigned FB_MIN_MS    = psdi_pkg::FEEDBACK_MIN_MS
)
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [1:0] mode_setting,
  input  wire logic       curtain_a_clear,
  input  wire logic       curtain_b_clear,
  input  wire logic       feedback_pin,
  input  wire logic       reset_pin,
  output var  logic       relay_a,
  output var  logic       relay_b,
  output var  logic       safety_output_state,
  output var  logic       fault,
  output var  logic       reset_needed
);

  localparam int unsigned MS_W = psdi_pkg::MS_W;

  // ----------------------------------------------------------------------
  // Millisecond tick divider
  // ----------------------------------------------------------------------
  logic [31:0] div_reg;
  wire         tick_ms;

  assign tick_ms = (div_reg == TICK_DIV - 1);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      div_reg <= '0;
    else
      div_reg <= tick_ms ? '0 : div_reg + 32'h1;
  end

  // ----------------------------------------------------------------------
  // Input synchronisers and redundant channels
  // ----------------------------------------------------------------------
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
    end
    else
    begin
      s1_reg <= {mode_setting, feedback_pin, reset_pin};
      s2_reg <= s1_reg;
    end
  end

  wire psdi_pkg::psdi_mode_t mode = psdi_pkg::psdi_mode_t'(s2_reg[3:2]);
  wire             fb_in    = s2_reg[1];
  wire             rst_in   = s2_reg[0];
  wire             clr_a;
  wire             clr_b;
  wire [MS_W-1:0]  brk_a;
  wire [MS_W-1:0]  brk_b;

  psdi_channel #(.MS_W(MS_W)) u_chan_a
  (
    .clock             (clock),
    .rst               (rst),
    .tick_ms           (tick_ms),
    .curtain_clear_pin (curtain_a_clear),
    .clear             (clr_a),
    .broken_ms         (brk_a)
  );

  psdi_channel #(.MS_W(MS_W)) u_chan_b
  (
    .clock             (clock),
    .rst               (rst),
    .tick_ms           (tick_ms),
    .curtain_clear_pin (curtain_b_clear),
    .clear             (clr_b),
    .broken_ms         (brk_b)
  );

  // Both channels must agree that the curtain is clear; a lasting
  // disagreement is treated as a fault rather than trusted.
  wire both_clear = clr_a && clr_b;
  wire any_break  = !clr_a || !clr_b;
  wire disagree   = clr_a ^ clr_b;

  // ----------------------------------------------------------------------
  // Edge detection on the synchronised inputs
  // ----------------------------------------------------------------------
  logic clear_d_reg;
  logic fb_d_reg;
  logic rst_d_reg;
  logic [MS_W-1:0] brk_len_reg;
  logic [MS_W-1:0] fb_ms_reg;
  logic [MS_W-1:0] disc_ms_reg;

  wire clear_rise  = both_clear && !clear_d_reg;
  wire reset_rise  = rst_in && !rst_d_reg;
  wire brk_min     = (brk_len_reg > BREAK_MIN_MS[MS_W-1:0]);
  wire valid_break = clear_rise && brk_min;
  wire fb_fall     = !fb_in && fb_d_reg;
  wire fb_valid    = fb_fall && (fb_ms_reg > FB_MIN_MS[MS_W-1:0]);
  wire disc_fault  = (disc_ms_reg > BREAK_MIN_MS[MS_W-1:0]);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      clear_d_reg <= 1'b0;
      fb_d_reg    <= 1'b0;
      rst_d_reg   <= 1'b0;
      brk_len_reg <= '0;
      fb_ms_reg   <= '0;
      disc_ms_reg <= '0;
    end
    else
    begin
      clear_d_reg <= both_clear;
      fb_d_reg    <= fb_in;
      rst_d_reg   <= rst_in;
      // Shorter of the two measured break lengths is the trusted one.
      brk_len_reg <= (brk_a < brk_b) ? brk_a : brk_b;
      if (!fb_in)
        fb_ms_reg <= '0;
      else if (tick_ms && !(&fb_ms_reg))
        fb_ms_reg <= fb_ms_reg + 1'b1;
      if (!disagree)
        disc_ms_reg <= '0;
      else if (tick_ms && !(&disc_ms_reg))
        disc_ms_reg <= disc_ms_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------------
  psdi_pkg::psdi_state_t state_reg;
  psdi_pkg::psdi_state_t state_next;
  logic [MS_W-1:0] wait_reg;
  logic [MS_W-1:0] wait_next;
  logic [1:0]      nbrk_reg;
  logic [1:0]      nbrk_next;
  logic            out_reg;
  logic            out_next;

  wire break_mode = (mode == psdi_pkg::PSDI_MODE_SINGLE) ||
                    (mode == psdi_pkg::PSDI_MODE_DOUBLE);
  wire [1:0] need = (mode == psdi_pkg::PSDI_MODE_DOUBLE) ?
                    2'(psdi_pkg::BREAKS_DOUBLE) :
                    2'(psdi_pkg::BREAKS_SINGLE);
  wire wait_over  = (wait_reg >= IDLE_WAIT_MS[MS_W-1:0]);
  wire wait_tick  = tick_ms && !wait_over;

  always_comb
  begin
    state_next = state_reg;
    wait_next  = wait_reg;
    nbrk_next  = nbrk_reg;
    out_next   = out_reg;
    case (state_reg)
      psdi_pkg::PSDI_ST_LOCKED:
      begin
        out_next = 1'b0;
        if (reset_rise && both_clear)
        begin
          nbrk_next = 2'h0;
          wait_next = '0;
          if (break_mode)
          begin
            // Initialisation releases the first cycle in break modes.
            state_next = psdi_pkg::PSDI_ST_CYCLE;
            out_next   = 1'b1;
          end
          else
          begin
            state_next = psdi_pkg::PSDI_ST_GUARD;
            out_next   = 1'b1;
          end
        end
      end
      psdi_pkg::PSDI_ST_CYCLE:
      begin
        if (any_break)
        begin
          // Intrusion during motion drops the relays at once.
          state_next = psdi_pkg::PSDI_ST_LOCKED;
          out_next   = 1'b0;
        end
        else if (fb_valid)
        begin
          state_next = psdi_pkg::PSDI_ST_WAIT;
          out_next   = 1'b0;
          wait_next  = '0;
          nbrk_next  = 2'h0;
        end
      end
      psdi_pkg::PSDI_ST_WAIT, psdi_pkg::PSDI_ST_BREAK:
      begin
        out_next = 1'b0;
        if (wait_tick)
          wait_next = wait_reg + 1'b1;
        if (wait_over)
          state_next = psdi_pkg::PSDI_ST_LOCKED;
        else if (any_break)
          state_next = psdi_pkg::PSDI_ST_BREAK;
        else if (valid_break)
        begin
          if (nbrk_reg + 2'h1 >= need)
          begin
            state_next = psdi_pkg::PSDI_ST_CYCLE;
            out_next   = 1'b1;
          end
          else
          begin
            state_next = psdi_pkg::PSDI_ST_WAIT;
            nbrk_next  = nbrk_reg + 2'h1;
          end
        end
        else if (clear_rise)
          state_next = psdi_pkg::PSDI_ST_WAIT;
      end
      psdi_pkg::PSDI_ST_GUARD:
      begin
        out_next = both_clear;
        if (any_break && mode == psdi_pkg::PSDI_MODE_MANUAL)
        begin
          state_next = psdi_pkg::PSDI_ST_LOCKED;
          out_next   = 1'b0;
        end
        else if (break_mode)
        begin
          state_next = psdi_pkg::PSDI_ST_LOCKED;
          out_next   = 1'b0;
        end
      end
      psdi_pkg::PSDI_ST_FAULT:
      begin
        out_next = 1'b0;
        if (reset_rise && !disagree)
          state_next = psdi_pkg::PSDI_ST_LOCKED;
      end
      default:
      begin
        state_next = psdi_pkg::PSDI_ST_LOCKED;
        out_next   = 1'b0;
      end
    endcase
    if (disc_fault)
    begin
      state_next = psdi_pkg::PSDI_ST_FAULT;
      out_next   = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= psdi_pkg::PSDI_ST_LOCKED;
      wait_reg  <= '0;
      nbrk_reg  <= 2'h0;
      out_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      nbrk_reg  <= nbrk_next;
      out_reg   <= out_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  psdi_pkg::psdi_out_t o;

  always_comb
  begin
    o.relay_a             = out_reg;
    o.relay_b             = out_reg;
    o.safety_output_state = out_reg;
    o.fault               = (state_reg == psdi_pkg::PSDI_ST_FAULT);
    o.reset_needed        = (state_reg == psdi_pkg::PSDI_ST_LOCKED);
  end

  assign relay_a             = o.relay_a;
  assign relay_b             = o.relay_b;
  assign safety_output_state = o.safety_output_state;
  assign fault               = o.fault;
  assign reset_needed        = o.reset_needed;

endmodule : psdi_ctrl

`default_nettype wire

// ==== testbench/psdi_ctrl_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module psdi_ctrl_checker
#(
  parameter int unsigned TICK_DIV     = 20000,
  parameter int unsigned IDLE_WAIT_MS = 30000
)
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [1:0] mode_setting,
  input wire logic       curtain_a_clear,
  input wire logic       curtain_b_clear,
  input wire logic       feedback_pin,
  input wire logic       reset_pin,
  input wire logic       relay_a,
  input wire logic       relay_b,
  input wire logic       safety_output_state,
  input wire logic       fault,
  input wire logic       reset_needed
);
  // ----------------------------------------------------------------------
  // Wait-state length counter
  // ----------------------------------------------------------------------
  // Slack covers the tick phase and the input synchronisers.
  localparam int unsigned WAIT_LIM = (IDLE_WAIT_MS + 2) * TICK_DIV + 8;
  logic [31:0] idle_cnt_reg;
  logic [31:0] idle_cnt_next;
  wire logic   waiting;
  assign waiting = !relay_a && !reset_needed && !fault && !mode_setting[1];
  assign idle_cnt_next = waiting ? idle_cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      idle_cnt_reg <= 32'h0;
    else
      idle_cnt_reg <= idle_cnt_next;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence seq_a_broken;
    $fell(curtain_a_clear) ##1 !curtain_a_clear [*6];
  endsequence
  sequence seq_b_broken;
    $fell(curtain_b_clear) ##1 !curtain_b_clear [*6];
  endsequence
  sequence seq_reset_held;
    $rose(reset_pin) && reset_needed
      ##1 (curtain_a_clear && curtain_b_clear && reset_pin) [*6];
  endsequence
  relays_equal_a: assert property (relay_a == relay_b)
    else $error("relay channels differ");
  status_follow_a: assert property ($stable(relay_a) |->
    safety_output_state == relay_a) else $error("status differs");
  hold_off_a: assert property ((reset_needed || fault) [*2] |->
    !relay_a && !relay_b) else $error("relays on while held");
  chan_a_drop_a: assert property (seq_a_broken |-> !relay_a)
    else $error("channel a break kept relays on");
  chan_b_drop_a: assert property (seq_b_broken |-> !relay_b)
    else $error("channel b break kept relays on");
  reset_unlock_a: assert property (seq_reset_held |-> !reset_needed)
    else $error("reset did not unlock");
  wait_bound_a: assert property (idle_cnt_reg <= WAIT_LIM)
    else $error("wait outlived its window");
  auto_follow_a: assert property ((mode_setting == 2'b10 &&
    curtain_a_clear && curtain_b_clear && !reset_needed && !fault) [*6]
    |-> relay_a) else $error("auto guard did not release");
endmodule : psdi_ctrl_checker
bind psdi_ctrl psdi_ctrl_checker #(.TICK_DIV(TICK_DIV),
  .IDLE_WAIT_MS(IDLE_WAIT_MS)) u_chk (.clock(clock), .rst(rst),
  .mode_setting(mode_setting), .curtain_a_clear(curtain_a_clear),
  .curtain_b_clear(curtain_b_clear), .feedback_pin(feedback_pin),
  .reset_pin(reset_pin), .relay_a(relay_a), .relay_b(relay_b),
  .safety_output_state(safety_output_state), .fault(fault),
  .reset_needed(reset_needed));
`default_nettype wire

// ==== testbench/psdi_field_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Curtain, machine feedback and operator reset; lines are always driven.
module psdi_field_model
#(
  parameter int unsigned MS_CLK = 20
)
(
  input  wire logic clock,
  output var  logic curtain_a_clear,
  output var  logic curtain_b_clear,
  output var  logic feedback_pin,
  output var  logic reset_pin
);
  initial
  begin
    curtain_a_clear = 1'b1;
    curtain_b_clear = 1'b1;
    feedback_pin    = 1'b0;
    reset_pin       = 1'b0;
  end
  task automatic hold(input int unsigned ms);
    repeat (ms * MS_CLK) @(posedge clock);
    #1;
  endtask : hold
  task automatic set_lines(input logic a, input logic b);
    @(posedge clock);
    #1;
    curtain_a_clear = a;
    curtain_b_clear = b;
  endtask : set_lines
  task automatic pulse_break(input logic both, input int unsigned ms);
    set_lines(1'b0, !both);
    hold(ms);
    curtain_a_clear = 1'b1;
    curtain_b_clear = 1'b1;
  endtask : pulse_break
  task automatic pulse_feedback(input int unsigned ms);
    @(posedge clock);
    #1;
    feedback_pin = 1'b1;
    hold(ms);
    feedback_pin = 1'b0;
  endtask : pulse_feedback
  task automatic press_reset;
    @(posedge clock);
    #1;
    reset_pin = 1'b1;
    hold(2);
    reset_pin = 1'b0;
  endtask : press_reset
endmodule : psdi_field_model
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int unsigned TICK = 20;
  localparam int unsigned IDLE = 150;
  logic       clock;
  logic       rst;
  logic [1:0] mode_setting;
  wire logic  curtain_a_clear;
  wire logic  curtain_b_clear;
  wire logic  feedback_pin;
  wire logic  reset_pin;
  wire logic  relay_a;
  wire logic  relay_b;
  wire logic  safety_output_state;
  wire logic  fault;
  wire logic  reset_needed;
  int         bad_count = 0;
  int         checked = 0;
  // Short tick, wait and break counts keep the run small; the feedback
  // minimum keeps its full value so the pulses below are real lengths.
  psdi_ctrl #(.TICK_DIV(TICK), .IDLE_WAIT_MS(IDLE),
    .BREAK_MIN_MS(30)) dut (.clock(clock), .rst(rst),
    .mode_setting(mode_setting), .curtain_a_clear(curtain_a_clear),
    .curtain_b_clear(curtain_b_clear), .feedback_pin(feedback_pin),
    .reset_pin(reset_pin), .relay_a(relay_a), .relay_b(relay_b),
    .safety_output_state(safety_output_state), .fault(fault),
    .reset_needed(reset_needed));
  // The field model's default of 20 clocks per millisecond matches TICK.
  psdi_field_model field (.clock(clock),
    .curtain_a_clear(curtain_a_clear), .curtain_b_clear(curtain_b_clear),
    .feedback_pin(feedback_pin), .reset_pin(reset_pin));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic wrap_up;
    $display("Checks made %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic seen, input logic want);
    checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, want, seen);
    end
  endtask : check
  // Relays answer a pin change within five clocks; eight leave margin.
  task automatic settle;
    repeat (8) @(posedge clock);
    #1;
  endtask : settle
  task automatic start(input logic [1:0] m);
    @(posedge clock);
    #1;
    mode_setting = m;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("locked", reset_needed, 1'b1);
    field.press_reset();
    settle();
    check("relay a", relay_a, 1'b1);
  endtask : start
  task automatic wait_lock;
    int unsigned n;
    n = 0;
    while (reset_needed !== 1'b1 && n < (IDLE + 5) * TICK)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    #1;
    check("lock delay", n >= (IDLE - 20) * TICK, 1'b1);
    if (reset_needed !== 1'b1)
    begin
      bad_count++;
      wrap_up();
    end
  endtask : wait_lock
  task automatic t_single;
    start(2'b00);
    field.pulse_feedback(50);
    settle();
    check("short feedback", relay_a, 1'b1);
    field.pulse_feedback(105);
    settle();
    check("cycle done", relay_b, 1'b0);
    check("status", safety_output_state, 1'b0);
    field.pulse_break(1'b1, 40);
    settle();
    check("one break", relay_a, 1'b1);
    field.pulse_feedback(105);
    settle();
    field.pulse_break(1'b1, 10);
    settle();
    check("short break", relay_a, 1'b0);
    wait_lock();
    $display("Test single done");
  endtask : t_single
  task automatic t_double;
    start(2'b01);
    field.pulse_feedback(105);
    field.pulse_break(1'b1, 40);
    settle();
    check("first break", relay_a, 1'b0);
    field.pulse_break(1'b1, 40);
    settle();
    check("second break", relay_a, 1'b1);
    field.pulse_feedback(105);
    wait_lock();
    $display("Test double done");
  endtask : t_double
  task automatic t_guards;
    start(2'b10);
    field.set_lines(1'b0, 1'b0);
    settle();
    check("auto break", relay_a, 1'b0);
    field.set_lines(1'b1, 1'b1);
    settle();
    check("auto clear", relay_b, 1'b1);
    check("status on", safety_output_state, 1'b1);
    start(2'b11);
    field.pulse_break(1'b1, 5);
    settle();
    check("manual break", relay_a, 1'b0);
    check("manual lock", reset_needed, 1'b1);
    field.press_reset();
    settle();
    check("manual reset", relay_a, 1'b1);
    $display("Test guards done");
  endtask : t_guards
  task automatic t_fault;
    start(2'b10);
    field.pulse_break(1'b0, 40);
    settle();
    check("fault", fault, 1'b1);
    check("fault relay", relay_b, 1'b0);
    field.press_reset();
    settle();
    check("fault left", fault, 1'b0);
    check("relocked", reset_needed, 1'b1);
    $display("Test fault done");
  endtask : t_fault
  initial
  begin
    rst = 1'b1;
    mode_setting = 2'b00;
    t_single();
    t_double();
    t_guards();
    t_fault();
    wrap_up();
  end
  initial
  begin
    repeat (90000) @(posedge clock);
    bad_count++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
